// ---- core/exception_frame_return_unit.v ----
// Exception frame builder and return-from-exception sequencer for short
// frames (formats 0 to 3). Stack memory is a 16-bit word port with a
// request held until a one-cycle acknowledge.
`timescale 1ns/1ps
`include "exc_frame_defines.vh"

module exception_frame_return_unit
(
    input wire clk,
    input wire rstn,
    input wire returnStart,
    input wire pushStart,
    input wire [3:0] pushKind,
    input wire pushThrowaway,
    input wire [11:0] pushVector,
    input wire [31:0] pushPc,
    input wire [31:0] pushAddr,
    input wire [15:0] curStatus,
    input wire [31:0] uspInit,
    input wire [31:0] ispInit,
    input wire [31:0] mspInit,
    input wire fpPostPending,
    input wire [15:0] memRdata,
    input wire memAck,
    output reg memReq,
    output reg memWe,
    output reg [31:0] memAddr,
    output reg [15:0] memWdata,
    output reg busy,
    output reg done,
    output reg formatError,
    output reg fpPostDispatch,
    output reg [15:0] statusOut,
    output reg [31:0] pcOut,
    output reg [31:0] uspOut,
    output reg [31:0] ispOut,
    output reg [31:0] mspOut
);

    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_RDFMT = 6'h02;
    localparam [5:0] ST_RDSR = 6'h04;
    localparam [5:0] ST_RDPCH = 6'h08;
    localparam [5:0] ST_RDPCL = 6'h10;
    localparam [5:0] ST_PUSH = 6'h20;

    reg [5:0] state_reg;
    reg [3:0] fmt_reg;
    reg [15:0] srTemp_reg;
    reg [15:0] pcHi_reg;
    reg [2:0] wordIdx_reg;
    reg [2:0] wordCnt_reg;
    reg [15:0] pushWord_reg [0:5];

    wire [3:0] pushFormat;
    reg [1:0] activeSel;
    reg [31:0] activeSp;
    reg [31:0] pushFrameSp;
    reg [31:0] pushAddrWord;
    integer i;
    reg [31:0] startSp;
    wire pushLong = (pushFormat == `FMT_SIXWORD) || (pushFormat == `FMT_FPPOST);
    wire [31:0] uspPop = uspOut + ((activeSel == `SP_USER) ? `ADJ_SHORT : 32'h0000_0000);
    wire [31:0] ispPop = ispOut + ((activeSel == `SP_INTR) ? `ADJ_SHORT : 32'h0000_0000);
    wire [31:0] mspPop = mspOut + ((activeSel == `SP_MAST) ? `ADJ_SHORT : 32'h0000_0000);
    wire [31:0] frameAdj = (fmt_reg == `FMT_NORMAL) ? `ADJ_SHORT : `ADJ_LONG;

    frame_format_select formatSel
    (
        .kind(pushKind),
        .throwaway(pushThrowaway),
        .format(pushFormat)
    );

    ////////////////////////////////////////////////////////////////////////
    // Stack selection from the live status word

    always @*
    begin
        if (!statusOut[`STAT_S_BIT])
            activeSel = `SP_USER;
        else if (statusOut[`STAT_M_BIT])
            activeSel = `SP_MAST;
        else
            activeSel = `SP_INTR;
        case (activeSel)
            `SP_MAST: activeSp = mspOut;
            `SP_INTR: activeSp = ispOut;
            default: activeSp = uspOut;
        endcase
    end

    // Push uses the caller's status, since statusOut may be stale then
    always @*
    begin
        if (!curStatus[`STAT_S_BIT])
            startSp = uspInit;
        else if (curStatus[`STAT_M_BIT])
            startSp = mspInit;
        else
            startSp = ispInit;
        if (pushLong)
            pushFrameSp = startSp - `ADJ_LONG;
        else
            pushFrameSp = startSp - `ADJ_SHORT;
        // Address error stacks the reference address less one
        if (pushKind == `KIND_ADDRERR)
            pushAddrWord = pushAddr - 32'h0000_0001;
        else
            pushAddrWord = pushAddr;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            fmt_reg <= 4'h0;
            srTemp_reg <= 16'h0000;
            pcHi_reg <= 16'h0000;
            wordIdx_reg <= 3'h0;
            wordCnt_reg <= 3'h0;
            for (i = 0; i < 6; i = i + 1)
                pushWord_reg[i] <= 16'h0000;
            memReq <= 1'b0;
            memWe <= 1'b0;
            memAddr <= 32'h0000_0000;
            memWdata <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
            formatError <= 1'b0;
            fpPostDispatch <= 1'b0;
            statusOut <= 16'h0000;
            pcOut <= 32'h0000_0000;
            uspOut <= 32'h0000_0000;
            ispOut <= 32'h0000_0000;
            mspOut <= 32'h0000_0000;
        end
        else
        begin
            done <= 1'b0;
            formatError <= 1'b0;
            fpPostDispatch <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (returnStart)
                    begin
                        statusOut <= curStatus;
                        uspOut <= uspInit;
                        ispOut <= ispInit;
                        mspOut <= mspInit;
                        busy <= 1'b1;
                        state_reg <= ST_RDFMT;
                        memReq <= 1'b1;
                        memWe <= 1'b0;
                        // Stack choice needs the new status, so take startSp decoded from curStatus
                        memAddr <= startSp + `OFS_FORMAT;
                    end
                    else if (pushStart)
                    begin
                        statusOut <= curStatus;
                        uspOut <= uspInit;
                        ispOut <= ispInit;
                        mspOut <= mspInit;
                        if (!curStatus[`STAT_S_BIT])
                            uspOut <= pushFrameSp;
                        else if (curStatus[`STAT_M_BIT])
                            mspOut <= pushFrameSp;
                        else
                            ispOut <= pushFrameSp;
                        pushWord_reg[0] <= curStatus;
                        pushWord_reg[1] <= pushPc[31:16];
                        pushWord_reg[2] <= pushPc[15:0];
                        pushWord_reg[3] <= {pushFormat, pushVector};
                        pushWord_reg[4] <= pushAddrWord[31:16];
                        pushWord_reg[5] <= pushAddrWord[15:0];
                        wordCnt_reg <= pushLong ? `WORDS_LONG : `WORDS_SHORT;
                        wordIdx_reg <= 3'h0;
                        busy <= 1'b1;
                        memReq <= 1'b1;
                        memWe <= 1'b1;
                        memAddr <= pushFrameSp + `OFS_STATUS;
                        memWdata <= curStatus;
                        state_reg <= ST_PUSH;
                    end
                end
                ST_PUSH:
                begin
                    if (memAck)
                    begin
                        if (wordIdx_reg + 3'h1 == wordCnt_reg)
                        begin
                            memReq <= 1'b0;
                            memWe <= 1'b0;
                            busy <= 1'b0;
                            done <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            wordIdx_reg <= wordIdx_reg + 3'h1;
                            memAddr <= memAddr + 32'h0000_0002;
                            memWdata <= pushWord_reg[wordIdx_reg + 3'h1];
                        end
                    end
                end
                ST_RDFMT:
                begin
                    if (memAck)
                    begin
                        fmt_reg <= memRdata[15:12];
                        if (memRdata[15:12] > `FMT_FPPOST)
                        begin
                            // Nothing restored; context stays as found
                            memReq <= 1'b0;
                            busy <= 1'b0;
                            formatError <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            memAddr <= activeSp + `OFS_STATUS;
                            state_reg <= ST_RDSR;
                        end
                    end
                end
                ST_RDSR:
                begin
                    if (memAck)
                    begin
                        if (fmt_reg == `FMT_THROWAWAY)
                        begin
                            uspOut <= uspPop;
                            ispOut <= ispPop;
                            mspOut <= mspPop;
                            statusOut <= memRdata;
                            // Next frame lives on whichever stack the new status picks
                            if (!memRdata[`STAT_S_BIT])
                                memAddr <= uspPop + `OFS_FORMAT;
                            else if (memRdata[`STAT_M_BIT])
                                memAddr <= mspPop + `OFS_FORMAT;
                            else
                                memAddr <= ispPop + `OFS_FORMAT;
                            state_reg <= ST_RDFMT;
                        end
                        else
                        begin
                            srTemp_reg <= memRdata;
                            memAddr <= activeSp + `OFS_PC_HI;
                            state_reg <= ST_RDPCH;
                        end
                    end
                end
                ST_RDPCH:
                begin
                    if (memAck)
                    begin
                        pcHi_reg <= memRdata;
                        memAddr <= activeSp + `OFS_PC_LO;
                        state_reg <= ST_RDPCL;
                    end
                end
                ST_RDPCL:
                begin
                    if (memAck)
                    begin
                        pcOut <= {pcHi_reg, memRdata};
                        statusOut <= srTemp_reg;
                        // Adjust on the stack that held the frame, before status flips
                        case (activeSel)
                            `SP_MAST: mspOut <= mspOut + frameAdj;
                            `SP_INTR: ispOut <= ispOut + frameAdj;
                            default: uspOut <= uspOut + frameAdj;
                        endcase
                        fpPostDispatch <= (fmt_reg == `FMT_FPPOST) && fpPostPending;
                        memReq <= 1'b0;
                        busy <= 1'b0;
                        done <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    memReq <= 1'b0;
                    memWe <= 1'b0;
                    busy <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- core/exc_frame_defines.vh ----
// Constants for the exception frame return unit: frame offsets, format codes,
// status word bit positions, stack adjustments and exception kind codes.
// Assumes 16-bit stack memory words addressed in bytes.
// Function
// - Return reads top frame, validates, dispatches by format
// - Format 0 restores status, PC, adds eight
// - Format 0 stacks status, PC, 0000 plus vector
// - Format 0 for interrupts, traps, illegal, privilege, FP-pre
// - Format 1: add eight, load status, restart return
// - After throwaway, reread frame on now-active stack
// - Throwaway frame type 0001 carries master-stack PC
// - Restored S and M select master stack next
// - Format 2 restores status, PC, adds twelve
// - Format 2: type 0010, address word at 8
// - Format 2 address word chosen by exception kind
// - Format 3: type 0011, operand address at 8
// - Format 3 restores status, PC, adds twelve
// - After format 3, dispatch pending FP-post exception
`ifndef EXC_FRAME_DEFINES_VH
`define EXC_FRAME_DEFINES_VH

`define OFS_STATUS 32'h0000_0000
`define OFS_PC_HI 32'h0000_0002
`define OFS_PC_LO 32'h0000_0004
`define OFS_FORMAT 32'h0000_0006
`define OFS_ADDR 32'h0000_0008

`define FMT_NORMAL 4'h0
`define FMT_THROWAWAY 4'h1
`define FMT_SIXWORD 4'h2
`define FMT_FPPOST 4'h3

`define ADJ_SHORT 32'h0000_0008
`define ADJ_LONG 32'h0000_000C

`define WORDS_SHORT 3'h4
`define WORDS_LONG 3'h6

`define STAT_S_BIT 13
`define STAT_M_BIT 12

`define SP_USER 2'h0
`define SP_INTR 2'h1
`define SP_MAST 2'h2

`define KIND_INTERRUPT 4'h0
`define KIND_FMTERR 4'h1
`define KIND_TRAP 4'h2
`define KIND_ILLEGAL 4'h3
`define KIND_ALINE 4'h4
`define KIND_FLINE 4'h5
`define KIND_PRIV 4'h6
`define KIND_FPPRE 4'h7
`define KIND_CHK 4'h8
`define KIND_TRAPCC 4'h9
`define KIND_TRAPV 4'hA
`define KIND_TRACE 4'hB
`define KIND_DIVZERO 4'hC
`define KIND_FPUNIMP 4'hD
`define KIND_ADDRERR 4'hE
`define KIND_FPPOST 4'hF

`endif

// ---- core/frame_format_select.v ----
// Maps an exception kind to its stack frame format.
// Assumes kind codes from exc_frame_defines.vh; purely combinational.
`timescale 1ns/1ps
`include "exc_frame_defines.vh"

module frame_format_select
(
    input wire [3:0] kind,
    input wire throwaway,
    output reg [3:0] format
);

    always @*
    begin
        format = `FMT_NORMAL;
        if (throwaway)
            format = `FMT_THROWAWAY;
        else
        begin
            case (kind)
                `KIND_CHK, `KIND_TRAPCC, `KIND_TRAPV, `KIND_TRACE,
                `KIND_DIVZERO, `KIND_FPUNIMP, `KIND_ADDRERR:
                    format = `FMT_SIXWORD;
                `KIND_FPPOST:
                    format = `FMT_FPPOST;
                default:
                    format = `FMT_NORMAL;
            endcase
        end
    end

endmodule

// ---- sim/stack_mem_model.sv ----
// Behavioural stack memory for the frame return unit, 16-bit words.
// Assumes byte addresses below 32'h200; acknowledge comes lag+1 cycles on.
`timescale 1ns/1ps
module stack_mem_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [31:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic [1:0] lag,
    output logic [15:0] memRdata,
    output logic memAck
);
    logic [15:0] mem [0:255];
    logic [15:0] lastData;
    logic [1:0] waitCnt;
    // Inverted off the acknowledge so stale data is never mistaken for valid
    assign memRdata = memAck ? lastData : ~lastData;
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            memAck <= 1'b0;
            waitCnt <= 2'h0;
            lastData <= 16'h0000;
        end
        else if (memReq && !memAck && waitCnt == lag)
        begin
            memAck <= 1'b1;
            waitCnt <= 2'h0;
            if (memWe)
                mem[memAddr[8:1]] <= memWdata;
            else
                lastData <= mem[memAddr[8:1]];
        end
        else
        begin
            memAck <= 1'b0;
            waitCnt <= (memReq && !memAck) ? waitCnt + 2'h1 : 2'h0;
        end
    end
endmodule

// ---- sim/frame_return_monitor.sv ----
// Checker for the return unit's memory handshake and result pulses.
// Assumes binding onto exception_frame_return_unit, one clock domain.
`timescale 1ns/1ps
module frame_return_monitor
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic returnStart,
    input wire logic pushStart,
    input wire logic [15:0] curStatus,
    input wire logic [31:0] ispInit,
    input wire logic [31:0] mspInit,
    input wire logic memAck,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [31:0] memAddr,
    input wire logic busy,
    input wire logic done,
    input wire logic formatError,
    input wire logic fpPostDispatch
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wire logic [31:0] firstAdr = (curStatus[12] ? mspInit : ispInit) + 32'h0000_0006;
    ////////////////////////////////////////
    a_first_read: assert property (returnStart && !busy && curStatus[13] |=>
        memReq && !memWe && memAddr == $past(firstAdr)) else $error("first read misplaced");
    a_start_busy: assert property ((returnStart || pushStart) && !busy |=>
        busy && memReq) else $error("start not taken");
    a_req_held: assert property (memReq && !memAck |=>
        memReq && $stable(memAddr) && $stable(memWe)) else $error("request changed");
    a_push_writes: assert property (pushStart && !returnStart && !busy |=>
        memWe [*4]) else $error("push not writing");
    a_done_pulse: assert property (done |=> !done) else $error("done too long");
    a_done_after_ack: assert property (done |->
        $past(memAck) && !memReq && !busy) else $error("done out of place");
    a_err_after_read: assert property (formatError |->
        $past(memAck) && !$past(memWe) && !done) else $error("format error out of place");
    a_disp_with_done: assert property (fpPostDispatch |-> done)
        else $error("dispatch without done");
    c_dispatch: cover property (fpPostDispatch);
    c_format_error: cover property (formatError);
    c_push_done: cover property (done && $past(memWe));
endmodule
bind exception_frame_return_unit frame_return_monitor i_frame_return_monitor (.clk(clk),
    .rstn(rstn), .returnStart(returnStart), .pushStart(pushStart), .curStatus(curStatus),
    .ispInit(ispInit), .mspInit(mspInit), .memAck(memAck), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .busy(busy), .done(done), .formatError(formatError),
    .fpPostDispatch(fpPostDispatch));

// ---- sim/testbench.sv ----
// Self-checking bench for the frame return unit with a stack memory model.
// Assumes the memory model answers with a selectable lag.
`timescale 1ns/1ps
module testbench;
    logic clk, rstn, returnStart, pushStart, pushThrowaway, fpPostPending;
    logic [3:0] pushKind;
    logic [11:0] pushVector;
    logic [31:0] pushPc, pushAddr, uspInit, ispInit, mspInit, memAddr;
    logic [15:0] curStatus, memRdata, memWdata, statusOut;
    logic memAck, memReq, memWe, busy, done, formatError, fpPostDispatch;
    logic [31:0] pcOut, uspOut, ispOut, mspOut;
    logic [1:0] lag;
    logic sawDone, sawErr, sawDisp;
    int num_errors = 0;
    int checks_done = 0;
    typedef struct packed {logic [3:0] fmt; logic fp; logic [7:0] adj; logic err; logic dsp;} row_t;
    row_t rows [6] = '{'{4'h0, 1'b1, 8'h08, 1'b0, 1'b0}, '{4'h2, 1'b1, 8'h0C, 1'b0, 1'b0},
        '{4'h3, 1'b0, 8'h0C, 1'b0, 1'b0}, '{4'h3, 1'b1, 8'h0C, 1'b0, 1'b1},
        '{4'h5, 1'b0, 8'h00, 1'b1, 1'b0}, '{4'hF, 1'b1, 8'h00, 1'b1, 1'b0}};
    exception_frame_return_unit i_exception_frame_return_unit (.clk(clk), .rstn(rstn),
        .returnStart(returnStart), .pushStart(pushStart), .pushKind(pushKind),
        .pushThrowaway(pushThrowaway), .pushVector(pushVector), .pushPc(pushPc),
        .pushAddr(pushAddr), .curStatus(curStatus), .uspInit(uspInit), .ispInit(ispInit),
        .mspInit(mspInit), .fpPostPending(fpPostPending), .memRdata(memRdata),
        .memAck(memAck), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
        .memWdata(memWdata), .busy(busy), .done(done), .formatError(formatError),
        .fpPostDispatch(fpPostDispatch), .statusOut(statusOut), .pcOut(pcOut),
        .uspOut(uspOut), .ispOut(ispOut), .mspOut(mspOut));
    stack_mem_model i_stack_mem_model (.clk(clk), .rstn(rstn), .memReq(memReq),
        .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .lag(lag),
        .memRdata(memRdata), .memAck(memAck));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkf(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] rd(input logic [31:0] a);
        return i_stack_mem_model.mem[a[8:1]];
    endfunction
    task automatic frame(input logic [31:0] sp, input logic [15:0] sr, fw, input logic [31:0] pc);
        i_stack_mem_model.mem[sp[8:1]] = sr;
        i_stack_mem_model.mem[sp[8:1] + 1] = pc[31:16];
        i_stack_mem_model.mem[sp[8:1] + 2] = pc[15:0];
        i_stack_mem_model.mem[sp[8:1] + 3] = fw;
    endtask
    task automatic run(input logic ret);
        int n;
        n = 0;
        sawDone = 1'b0;
        sawErr = 1'b0;
        @(negedge clk);
        returnStart = ret;
        pushStart = !ret;
        @(negedge clk);
        returnStart = 1'b0;
        pushStart = 1'b0;
        while (!sawDone && !sawErr && n < 100)
        begin
            @(negedge clk);
            sawDone = (done === 1'b1);
            sawErr = (formatError === 1'b1);
            sawDisp = (fpPostDispatch === 1'b1);
            n++;
        end
        chkf(n < 100, 1'b1);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #(40 * 4000);
        num_errors++;
        wrap_up;
    end
    initial
    begin
        logic [3:0] f;
        logic [31:0] b;
        {rstn, returnStart, pushStart, pushThrowaway, fpPostPending, lag} = 7'h00;
        {pushKind, pushVector, pushPc, pushAddr} = 80'h0;
        uspInit = 32'h0000_0180;
        ispInit = 32'h0000_0080;
        mspInit = 32'h0000_0100;
        curStatus = 16'h3000;
        repeat (12) @(negedge clk);
        chk({done, busy, memReq, formatError, statusOut}, 32'h0);
        chk(mspOut, 32'h0);
        rstn = 1'b1;
        $display("reset test done");
        for (int i = 0; i < 6; i++)
        begin
            lag = i[1:0];
            fpPostPending = rows[i].fp;
            frame(32'h100, 16'h2700 + 16'(i), {rows[i].fmt, 12'(i * 4)}, 32'h1000_0000 + i);
            run(1'b1);
            chkf(sawErr, rows[i].err);
            chkf(sawDone, !rows[i].err);
            chkf(sawDisp, rows[i].dsp);
            chk(mspOut, 32'h100 + rows[i].adj);
            if (!rows[i].err)
                chk({statusOut, pcOut[15:0]}, {16'h2700 + 16'(i), 16'(i)});
            $display("return row %0d done", i);
        end
        @(negedge clk);
        returnStart = 1'b1;
        @(negedge clk);
        {returnStart, rstn} = 2'b00;
        @(negedge clk);
        chkf(busy, 1'b0);
        chk({memReq, memAddr[15:0], done, formatError}, 32'h0);
        rstn = 1'b1;
        @(negedge clk);
        chk({busy, memReq}, 32'h0);
        $display("mid-run reset done");
        curStatus = 16'h2000;
        frame(32'h80, 16'h3000, 16'h1000, 32'h0);
        frame(32'h100, 16'h2400, 16'h0000, 32'h0000_4444);
        run(1'b1);
        chk(ispOut, 32'h88);
        chk(mspOut, 32'h108);
        chk({statusOut, pcOut[15:0]}, 32'h2400_4444);
        $display("throwaway return done");
        curStatus = 16'h3000;
        frame(32'h100, 16'h3000, 16'h1000, 32'h0);
        frame(32'h108, 16'h2300, 16'h0000, 32'h0000_5555);
        run(1'b1);
        chk(mspOut, 32'h110);
        chk(uspOut, 32'h180);
        chk({statusOut, pcOut[15:0]}, 32'h2300_5555);
        $display("master throwaway return done");
        curStatus = 16'h3000;
        pushPc = 32'h1234_5678;
        pushAddr = 32'h0000_9000;
        for (int k = 0; k < 16; k++)
        begin
            pushKind = k[3:0];
            pushVector = 12'(k * 4);
            lag = k[1:0];
            f = (k < 8) ? 4'h0 : ((k < 15) ? 4'h2 : 4'h3);
            b = (f == 4'h0) ? 32'h0F8 : 32'h0F4;
            run(1'b0);
            chk(mspOut, b);
            chk({rd(b), rd(b + 6)}, {16'h3000, f, pushVector});
            chk({rd(b + 2), rd(b + 4)}, pushPc);
            if (f != 4'h0)
                chk({rd(b + 8), rd(b + 10)}, (k == 14) ? 32'h8FFF : 32'h9000);
        end
        $display("push kinds done");
        curStatus = 16'h2000;
        pushKind = 4'h0;
        pushThrowaway = 1'b1;
        run(1'b0);
        chk(ispOut, 32'h78);
        chk({rd(32'h7E), rd(32'h7C)}, {16'h1000 | 16'(pushVector), 16'h5678});
        $display("throwaway push done");
        wrap_up;
    end
endmodule
